// [shared/chg_pkg.sv]
// Constants, field layout and state types of the charger status-flag block.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
package chg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ            = 200;
  localparam int          ALERT_DELAY_US     = 8000;  // Centre of the 6 to 10 ms window
  localparam int          ALERT_MIN_US       = 6000;
  localparam int          ALERT_MAX_US       = 10000;
  localparam int          DEGLITCH_US        = 8000;
  localparam int          COUNT_W            = 24;
  localparam logic [23:0] ALERT_CYCLES       = 24'(ALERT_DELAY_US * CLK_MHZ);
  localparam logic [23:0] DEGLITCH_CYCLES    = 24'(DEGLITCH_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 10;
  localparam logic [7:0]  IDX_CTRL           = 8'h12;
  localparam logic [7:0]  IDX_STATUS         = 8'h13;
  localparam logic [7:0]  IDX_VOLT           = 8'h15;
  localparam logic [7:0]  IDX_IRQ_STAT       = 8'h20;
  localparam logic [7:0]  IDX_IRQ_MASK       = 8'h21;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_INHIBIT_BIT   = 0;
  localparam int          CTRL_LEARN_BIT     = 4;
  localparam int          CTRL_DEP_LSB       = 9;
  localparam int          CTRL_DEP_MSB       = 11;
  localparam int          ST_DEPLETED_BIT    = 11;
  localparam int          ST_RANGE_BIT       = 12;
  localparam int          ST_BAT_OVER_BIT    = 13;
  localparam int          ST_BAT_PRES_BIT    = 14;
  localparam int          ST_ADAPTER_BIT     = 15;
  localparam logic [15:0] STATUS_MASK        = 16'hF800;
  localparam logic [15:0] CTRL_RST           = 16'h0000;
  localparam logic [15:0] VOLT_RST           = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RST       = 16'h0000;

  // ----------------------------------------------------------------
  // Charge voltage decode, millivolts
  // ----------------------------------------------------------------
  localparam logic [15:0] V_WAKE_MV          = 16'h2328;  // 9000
  localparam logic [15:0] V3_LO_MV           = 16'h2EE0;  // 12000
  localparam logic [15:0] V3_HI_MV           = 16'h3840;  // 14400
  localparam logic [15:0] V4_LO_MV           = 16'h3E80;  // 16000
  localparam logic [15:0] V4_HI_MV           = 16'h4B00;  // 19200
  localparam logic [15:0] VSTEP_MASK         = 16'hFFF0;  // 16 mV converter step
  localparam logic [15:0] DEP_BASE_MV        = 16'h0AF0;  // 2800 per cell
  localparam logic [15:0] DEP_STEP_MV        = 16'h0064;  // 100 per code

  // ----------------------------------------------------------------
  // Comparator inputs, one bit each in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int          NIN                = 8;
  localparam int          IN_ADAPTER         = 0;
  localparam int          IN_POR_ADAPTER     = 1;
  localparam int          IN_POR_SUPPLY      = 2;
  localparam int          IN_BAT_DETECT      = 3;
  localparam int          IN_BAT_OVER_ADP    = 4;
  localparam int          IN_NEAR_BAT        = 5;
  localparam int          IN_HYST_CLEAR      = 6;
  localparam int          IN_BAT_DEPLETED    = 7;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BYP_OFF  = 3'b001,
    BYP_WAIT = 3'b010,
    BYP_ON   = 3'b100
  } chg_byp_type;

  typedef enum logic [2:0] {
    ALR_IDLE = 3'b001,
    ALR_WAIT = 3'b010,
    ALR_HIGH = 3'b100
  } chg_alr_type;

  typedef struct packed {
    logic [NIN-1:0]     s1;
    logic [NIN-1:0]     s2;
    logic [NIN-1:0]     s3;
    logic [NIN-1:0]     lvl;
    logic [15:0]        ctrl;
    logic [15:0]        volt;
    logic [15:0]        irq_stat;
    logic [15:0]        irq_mask;
    logic [15:0]        prev_stat;
    logic               aw_got;
    logic [ADDR_W-1:0]  awaddr;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    chg_byp_type        byp;
    logic [COUNT_W-1:0] byp_cnt;
    chg_alr_type        alr;
    logic [COUNT_W-1:0] alr_cnt;
    logic               bat_fet;
    logic               adp_fet;
    logic               chg_en;
    logic               vref_en;
    logic               gdr_en;
    logic [15:0]        target;
    logic [15:0]        dep_thr;
  } chg_state_type;

endpackage

// [verilog/chg_flags.sv]
// Status flags, protection decisions and register slave of the charger.
// Assumes comparator outputs arrive asynchronously and one AXI4-Lite master.
//
// What this block does
// - Status bit 11 high while battery is below the selected depleted threshold.
// - Depleted threshold is per cell, times three or four cells from voltage.
// - Depleted battery turns battery FET off; adapter FET on if learning with adapter.
// - Status bit 12 high while programmed charge voltage is outside valid range.
// - Valid voltages 9 V, 12-14.4 V, 16-19.2 V; rounded down to converter step.
// - Above 19.2 V charging stays enabled and target clamps to 19.2 V.
// - Below 12 V (not 9 V) or 14.4-16 V: no charge, flag, alert.
// - A value of 9000 mV regulates 9 V for battery wake-up.
// - Status bit 13 high while battery voltage exceeds adapter voltage.
// - Bypass FET off at once near battery; back on after 8 ms and hysteresis.
// - Status bit 14 high while thermistor sense is below detect threshold.
// - Charging stops at once, autonomously, when no battery is detected.
// - Status bit 15 high while adapter detect is above its threshold.
// - No charging and five volt reference off until adapter is detected.
// - Bus answers only once adapter detect and supply pass their wake levels.
// - Alert rises 6 to 10 ms after any status bit toggles.
// - Adapter connects to system only while present and learn mode is off or battery is depleted.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module chg_flags
  import chg_pkg::*;
#(
  parameter logic [23:0] ALERT_CYCLES_P    = ALERT_CYCLES,
  parameter logic [23:0] DEGLITCH_CYCLES_P = DEGLITCH_CYCLES
)(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              adapter_detect_input,
  input  wire logic              adapter_wake_input,
  input  wire logic              supply_wake_input,
  input  wire logic              thermistor_sense_input,
  input  wire logic              battery_over_adapter_input,
  input  wire logic              input_near_battery_input,
  input  wire logic              input_hysteresis_clear_input,
  input  wire logic              battery_below_depleted_input,
  output logic                   battery_fet_drive,
  output logic                   adapter_fet_drive,
  output logic                   bypass_fet_drive,
  output logic                   charge_enable,
  output logic                   five_volt_reference,
  output logic                   gate_drive_regulator,
  output logic [15:0]            regulation_target_mv,
  output logic [15:0]            battery_depleted_threshold,
  output logic                   alert,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  // Only the low two byte lanes carry data; upper lanes are dropped.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = data[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  chg_state_type     r;
  chg_state_type     next_r;
  logic [NIN-1:0]    pins;
  logic [15:0]       status;
  logic [15:0]       toggles;
  logic              bus_on;
  logic              depleted;
  logic              adapter;
  logic              bat_present;
  logic              learn;
  logic              v_bad;
  logic              chg_ok;
  logic              cells4;
  logic [15:0]       v_trunc;
  logic [15:0]       target;
  logic [15:0]       per_cell;
  logic              wr_do;
  logic              rd_do;
  logic              rd_status;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [15:0]       rd_val;
  logic              rd_hit;

  assign pins[IN_ADAPTER]      = adapter_detect_input;
  assign pins[IN_POR_ADAPTER]  = adapter_wake_input;
  assign pins[IN_POR_SUPPLY]   = supply_wake_input;
  assign pins[IN_BAT_DETECT]   = thermistor_sense_input;
  assign pins[IN_BAT_OVER_ADP] = battery_over_adapter_input;
  assign pins[IN_NEAR_BAT]     = input_near_battery_input;
  assign pins[IN_HYST_CLEAR]   = input_hysteresis_clear_input;
  assign pins[IN_BAT_DEPLETED] = battery_below_depleted_input;

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  assign bus_on      = r.lvl[IN_POR_ADAPTER] & r.lvl[IN_POR_SUPPLY];
  assign depleted    = r.lvl[IN_BAT_DEPLETED];
  assign adapter     = r.lvl[IN_ADAPTER];
  assign bat_present = r.lvl[IN_BAT_DETECT];
  assign learn       = r.ctrl[CTRL_LEARN_BIT];
  assign v_trunc     = r.volt & VSTEP_MASK;

  always_comb begin
    v_bad  = 1'b0;
    chg_ok = 1'b1;
    cells4 = 1'b0;
    target = v_trunc;
    if (r.volt == V_WAKE_MV) begin
      target = V_WAKE_MV;
    end else if (r.volt >= V3_LO_MV && r.volt <= V3_HI_MV) begin
      cells4 = 1'b0;
    end else if (r.volt >= V4_LO_MV && r.volt <= V4_HI_MV) begin
      cells4 = 1'b1;
    end else if (r.volt > V4_HI_MV) begin
      v_bad  = 1'b1;
      cells4 = 1'b1;
      target = V4_HI_MV;
    end else begin
      v_bad  = 1'b1;
      chg_ok = 1'b0;
      target = 16'h0000;
    end
  end

  assign per_cell = DEP_BASE_MV + 16'(r.ctrl[CTRL_DEP_MSB:CTRL_DEP_LSB]) * DEP_STEP_MV;

  // Flags are rebuilt from live levels, never stored by a write
  always_comb begin
    status                  = 16'h0000;
    status[ST_DEPLETED_BIT] = depleted;
    status[ST_RANGE_BIT]    = v_bad;
    status[ST_BAT_OVER_BIT] = r.lvl[IN_BAT_OVER_ADP];
    status[ST_BAT_PRES_BIT] = bat_present;
    status[ST_ADAPTER_BIT]  = adapter;
  end

  assign toggles = (status ^ r.prev_stat) & STATUS_MASK;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign s_axi_awready = bus_on & ~r.aw_got & ~r.bvalid;
  assign s_axi_wready  = bus_on & ~r.w_got & ~r.bvalid;
  assign s_axi_arready = bus_on & ~r.rvalid;

  assign wr_addr = r.aw_got ? r.awaddr : s_axi_awaddr;
  assign wr_data = r.w_got ? r.wdata : s_axi_wdata;
  assign wr_strb = r.w_got ? r.wstrb : s_axi_wstrb;
  assign wr_do   = (r.aw_got | (s_axi_awvalid & s_axi_awready))
                 & (r.w_got | (s_axi_wvalid & s_axi_wready));
  assign rd_do   = s_axi_arvalid & s_axi_arready;
  assign rd_status = rd_do & hit(s_axi_araddr, IDX_STATUS);

  always_comb begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    if (hit(s_axi_araddr, IDX_CTRL)) begin
      rd_val = r.ctrl;
    end else if (hit(s_axi_araddr, IDX_STATUS)) begin
      rd_val = status;
    end else if (hit(s_axi_araddr, IDX_VOLT)) begin
      rd_val = r.volt;
    end else if (hit(s_axi_araddr, IDX_IRQ_STAT)) begin
      rd_val = r.irq_stat;
    end else if (hit(s_axi_araddr, IDX_IRQ_MASK)) begin
      rd_val = r.irq_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;

    // Three-stage sync; a level moves only when stages two and three agree
    next_r.s1  = pins;
    next_r.s2  = r.s1;
    next_r.s3  = r.s2;
    next_r.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));

    next_r.prev_stat = status;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid & s_axi_awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end

    // Event sets are applied after the clear so a coincident event survives
    next_r.irq_stat = r.irq_stat;
    if (wr_do) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      if (hit(wr_addr, IDX_CTRL)) begin
        next_r.ctrl = merge(r.ctrl, wr_data, wr_strb);
      end else if (hit(wr_addr, IDX_VOLT)) begin
        next_r.volt = merge(r.volt, wr_data, wr_strb);
      end else if (hit(wr_addr, IDX_IRQ_STAT)) begin
        next_r.irq_stat = r.irq_stat & ~merge(16'h0000, wr_data, wr_strb);
      end else if (hit(wr_addr, IDX_IRQ_MASK)) begin
        next_r.irq_mask = merge(r.irq_mask, wr_data, wr_strb) & STATUS_MASK;
      end else if (!hit(wr_addr, IDX_STATUS)) begin
        next_r.bresp = RESP_SLVERR;
      end
    end else if (r.bvalid & s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    next_r.irq_stat = next_r.irq_stat | toggles;

    if (rd_do) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = {16'h0000, rd_val};
      next_r.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid & s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Bypass FET: drop at once, return only after a quiet deglitch span
    next_r.byp_cnt = '0;
    unique case (r.byp)
      BYP_OFF: begin
        if (!r.lvl[IN_NEAR_BAT] && r.lvl[IN_HYST_CLEAR]) begin
          next_r.byp = BYP_WAIT;
        end
      end
      BYP_WAIT: begin
        if (r.lvl[IN_NEAR_BAT] || !r.lvl[IN_HYST_CLEAR]) begin
          next_r.byp = BYP_OFF;
        end else if (r.byp_cnt == DEGLITCH_CYCLES_P - 24'h000001) begin
          next_r.byp = BYP_ON;
        end else begin
          next_r.byp_cnt = r.byp_cnt + 24'h000001;
        end
      end
      BYP_ON: begin
        if (r.lvl[IN_NEAR_BAT]) begin
          next_r.byp = BYP_OFF;
        end
      end
      default: begin
        next_r.byp = BYP_OFF;
      end
    endcase

    // Alert: delayed rise after a toggle, dropped by a status read
    next_r.alr_cnt = '0;
    unique case (r.alr)
      ALR_IDLE: begin
        if (|toggles) begin
          next_r.alr = ALR_WAIT;
        end
      end
      ALR_WAIT: begin
        if (r.alr_cnt == ALERT_CYCLES_P - 24'h000001) begin
          next_r.alr = ALR_HIGH;
        end else begin
          next_r.alr_cnt = r.alr_cnt + 24'h000001;
        end
      end
      ALR_HIGH: begin
        if (rd_status) begin
          next_r.alr = (|toggles) ? ALR_WAIT : ALR_IDLE;
        end
      end
      default: begin
        next_r.alr = ALR_IDLE;
      end
    endcase

    // Power path and charger decisions
    next_r.bat_fet = ~depleted;
    next_r.adp_fet = adapter & (~learn | depleted);
    next_r.chg_en  = adapter & bat_present & chg_ok
                   & ~r.ctrl[CTRL_INHIBIT_BIT];
    next_r.vref_en = adapter;
    next_r.gdr_en  = bus_on;
    next_r.target  = target;
    next_r.dep_thr = cells4 ? (per_cell << 2) : ((per_cell << 1) + per_cell);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.ctrl     <= CTRL_RST;
      r.volt     <= VOLT_RST;
      r.irq_mask <= IRQ_MASK_RST;
      r.byp      <= BYP_OFF;
      r.alr      <= ALR_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid               = r.bvalid;
  assign s_axi_bresp                = r.bresp;
  assign s_axi_rvalid               = r.rvalid;
  assign s_axi_rdata                = r.rdata;
  assign s_axi_rresp                = r.rresp;
  assign battery_fet_drive          = r.bat_fet;
  assign adapter_fet_drive          = r.adp_fet;
  assign bypass_fet_drive           = (r.byp == BYP_ON);
  assign charge_enable              = r.chg_en;
  assign five_volt_reference        = r.vref_en;
  assign gate_drive_regulator       = r.gdr_en;
  assign regulation_target_mv       = r.target;
  assign battery_depleted_threshold = r.dep_thr;
  assign alert                      = (r.alr == ALR_HIGH);
  assign irq                        = |(r.irq_stat & r.irq_mask);

endmodule

// [verif/chg_flags_properties.sv]
// Concurrent checks on the charger flag block, seen from its top-level ports only.
// Assumes the bench binds it to chg_flags and holds every input stable for many cycles.
`timescale 1ns/1ps

module chg_flags_properties
  import chg_pkg::*;
#(
  parameter logic [23:0] ALERT_CYCLES_P    = ALERT_CYCLES,
  parameter logic [23:0] DEGLITCH_CYCLES_P = DEGLITCH_CYCLES
)(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arready,
  input wire logic        adapter_detect_input,
  input wire logic        adapter_wake_input,
  input wire logic        thermistor_sense_input,
  input wire logic        battery_below_depleted_input,
  input wire logic        input_near_battery_input,
  input wire logic        battery_fet_drive,
  input wire logic        adapter_fet_drive,
  input wire logic        bypass_fet_drive,
  input wire logic        charge_enable,
  input wire logic        five_volt_reference,
  input wire logic [15:0] regulation_target_mv
);
  // ----
  // Seven stable cycles cover the synchroniser plus the output flop
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  bat_fet_off_a: assert property (battery_below_depleted_input [*7] |=> !battery_fet_drive)
    else $error("battery fet on while depleted");
  no_adp_path_a: assert property (!adapter_detect_input [*7] |=> !charge_enable && !adapter_fet_drive)
    else $error("charge or adapter path without adapter");
  vref_follow_a: assert property (adapter_detect_input [*7] |=> five_volt_reference)
    else $error("reference off with adapter present");
  vref_off_a: assert property (!adapter_detect_input [*7] |=> !five_volt_reference)
    else $error("reference on without adapter");
  no_bat_stop_a: assert property (!thermistor_sense_input [*7] |=> !charge_enable)
    else $error("charging with no battery");
  byp_off_a: assert property (input_near_battery_input [*7] |=> !bypass_fet_drive)
    else $error("bypass fet on near battery");
  byp_rise_a: assert property ($rose(bypass_fet_drive) |-> !$past(input_near_battery_input, 8))
    else $error("bypass fet on without deglitch");
  bus_silent_a: assert property (!adapter_wake_input [*7] |-> !s_axi_awready && !s_axi_arready)
    else $error("bus answers before wake");
  target_clamp_a: assert property (regulation_target_mv <= 16'h4B00)
    else $error("target above maximum");
  charge_target_a: assert property (charge_enable |-> regulation_target_mv >= 16'h2328)
    else $error("charging with invalid target");
endmodule

// [verif/chg_host_model.sv]
// Host model: AXI4-Lite master whose tasks the bench calls.
// Assumes slave readies and answers are settled by the falling edge of mclk.
`timescale 1ns/1ps

module chg_host_model
  import chg_pkg::*;
(
  input  wire logic              mclk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge mclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    do begin
      @(negedge mclk);
      ta = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge mclk);
    end while (!ta);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge mclk);
      t = s_axi_arready;
      @(posedge mclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge mclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench: host model drives the registers, bench drives comparators.
// Assumes shortened alert and deglitch counts of 20 cycles.
`timescale 1ns/1ps

module testbench;
  import chg_pkg::*;
  logic mclk, rst_b, irq, alert, battery_fet_drive, adapter_fet_drive, bypass_fet_drive;
  logic charge_enable, five_volt_reference, gate_drive_regulator;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] regulation_target_mv, battery_depleted_threshold, ctl, volt;
  logic [7:0] inp;
  logic adapter_detect_input, thermistor_sense_input, battery_over_adapter_input;
  logic battery_below_depleted_input, input_near_battery_input, input_hysteresis_clear_input;
  logic adapter_wake_input, supply_wake_input;
  int n_mismatch, cmp_count, t, c, ok, bad;
  logic [15:0] vt [10] = '{16'h2328, 16'h2EE0, 16'h3840, 16'h32CD, 16'h3A98,
                           16'h3E80, 16'h4B00, 16'h4E20, 16'h2AF8, 16'h4000};

  chg_flags #(.ALERT_CYCLES_P(24'h14), .DEGLITCH_CYCLES_P(24'h14)) chg_flags_i (.*);
  chg_host_model chg_host_model_i (.*);

  assign {supply_wake_input, adapter_wake_input, input_hysteresis_clear_input,
          input_near_battery_input, battery_below_depleted_input, battery_over_adapter_input,
          thermistor_sense_input, adapter_detect_input} = inp;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic void vdec(input int v, output int t, output int c, output int ok,
                               output int bad);
    {t, c, ok, bad} = {32'd0, 32'd0, 32'd0, 32'd1};
    if (v == 9000) {t, c, ok, bad} = {v, 32'd3, 32'd1, 32'd0};
    else if (v >= 12000 && v <= 14400) {t, c, ok, bad} = {v & 32'hFFF0, 32'd3, 32'd1, 32'd0};
    else if (v >= 16000 && v <= 19200) {t, c, ok, bad} = {v & 32'hFFF0, 32'd4, 32'd1, 32'd0};
    else if (v > 19200) {t, c, ok} = {32'd19200, 32'd4, 32'd1};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic setin(input logic [7:0] v);
    @(posedge mclk);
    inp <= v;
  endtask

  task automatic check_all();
    vdec(volt, t, c, ok, bad);
    chg_host_model_i.rd(10'h4C, d, r);
    chk(d, {16'h0, inp[0], inp[1], inp[2], bad[0], inp[3], 11'h0});
    chk(regulation_target_mv, t);
    chk(charge_enable, inp[0] & inp[1] & ok[0] & !ctl[0]);
    chk(battery_fet_drive, !inp[3]);
    chk(adapter_fet_drive, inp[0] & (!ctl[4] | inp[3]));
    chk(five_volt_reference, inp[0]);
    if (c != 0) chk(battery_depleted_threshold, (2800 + 100 * ctl[11:9]) * c);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    inp = 8'h00;
    rst_b = 1'b0;
    seed = 32'h76df;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    cyc(8);
    chk(s_axi_arready, 1'b0);
    setin(8'hE3);
    cyc(8);
    chk(gate_drive_regulator, 1'b1);
    foreach (vt[i]) begin
      seed = lfsr(lfsr(seed));
      ctl = seed[15:0] & 16'h0E11;
      volt = vt[i];
      chg_host_model_i.wr(10'h48, {16'h0, ctl}, r);
      chg_host_model_i.wr(10'h54, {16'h0, volt}, r);
      chk(r, RESP_OKAY);
      setin({4'hE, seed[19:16] | ((i < 4) ? 4'h3 : 4'h0)});
      cyc(8);
      check_all();
    end
    chg_host_model_i.wr(10'h4C, 32'h0, r);
    chk(r, RESP_OKAY);
    check_all();
    chg_host_model_i.rd(10'h3FC, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    chg_host_model_i.wr(10'h84, 32'hFFFF, r);
    chg_host_model_i.rd(10'h84, d, r);
    chk(d, 32'hF800);
    cyc(2);
    chk(irq, 1'b1);
    chg_host_model_i.wr(10'h80, 32'hF800, r);
    cyc(2);
    chk(irq, 1'b0);
    chg_host_model_i.wr(10'h84, 32'h0, r);
    cyc(40);
    chg_host_model_i.rd(10'h4C, d, r);
    cyc(2);
    chk(alert, 1'b0);
    setin(inp ^ 8'h02);
    cyc(12);
    chk(alert, 1'b0);
    chk(irq, 1'b0);
    cyc(30);
    chk(alert, 1'b1);
    chg_host_model_i.rd(10'h80, d, r);
    chk(d, 32'h4000);
    chg_host_model_i.rd(10'h4C, d, r);
    cyc(2);
    chk(alert, 1'b0);
    setin((inp & 8'hCF) | 8'h10);
    cyc(8);
    chk(bypass_fet_drive, 1'b0);
    setin((inp & 8'hCF) | 8'h20);
    cyc(12);
    chk(bypass_fet_drive, 1'b0);
    cyc(30);
    chk(bypass_fet_drive, 1'b1);
    print_verdict();
  end
endmodule

bind chg_flags chg_flags_properties #(
  .ALERT_CYCLES_P(ALERT_CYCLES_P),
  .DEGLITCH_CYCLES_P(DEGLITCH_CYCLES_P)
) chg_flags_properties_i (.*);
